//--- bfwa_ctrl.v
// terminal-side controller: size query, write sequence and activation of the biometric file
// assumes one clock shared with the link layer; the link returns a status word per command
`timescale 1ns/1ps
`include "bfwa_defs.vh"

// ****************************************************************
// payload fifo
// ****************************************************************
module bfwa_fifo #(
    parameter W  = 8,
    parameter D  = 32,
    parameter AW = 5
) (
    // clock and reset
    input  wire          sys_clk_i,
    input  wire          rst_i,
    // fill side
    input  wire          in_valid_i,
    output wire          in_ready_o,
    input  wire [W-1:0]  in_data_i,
    // drain side
    output wire          out_valid_o,
    input  wire          out_ready_i,
    output wire [W-1:0]  out_data_o
);
    reg [W-1:0]  mem_reg [0:D-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0]   cnt_reg;
    reg          rdy_reg;
    reg          vld_reg;
    wire         push;
    wire         pop;
    reg [AW:0]   cnt_next;

    assign push        = in_valid_i && rdy_reg;
    assign pop         = out_ready_i && vld_reg;
    assign in_ready_o  = rdy_reg;
    assign out_valid_o = vld_reg;
    assign out_data_o  = mem_reg[rd_reg];

    always @* begin
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always @(posedge sys_clk_i) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_i;
        end
    end

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
            rdy_reg <= 1'b0;
            vld_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == D - 1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == D - 1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_next;
            rdy_reg <= (cnt_next < D);
            vld_reg <= (cnt_next != {(AW+1){1'b0}});
        end
    end
endmodule // bfwa_fifo

// ****************************************************************
// sequence controller
// ****************************************************************
module bfwa_ctrl #(
    parameter BLK = 64
) (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        rst_i,
    // user command
    input  wire        start_i,
    input  wire [7:0]  file_id_i,
    input  wire [15:0] total_len_i,
    input  wire        hint_en_i,
    // user data stream
    input  wire        data_valid_i,
    output wire        data_ready_o,
    input  wire [7:0]  data_i,
    // command bytes to the link
    output reg         tx_valid_o,
    input  wire        tx_ready_i,
    output reg  [7:0]  tx_data_o,
    output reg         tx_last_o,
    // answers from the link
    input  wire        rsp_valid_i,
    input  wire [15:0] rsp_sw_i,
    input  wire [15:0] rsp_free_i,
    // user status
    output reg         busy_o,
    output reg         done_o,
    output reg         err_o,
    output reg  [15:0] err_sw_o,
    output reg         activated_o
);
    localparam S_IDLE = 3'h0;
    localparam S_LOAD = 3'h1;
    localparam S_SEND = 3'h2;
    localparam S_WAIT = 3'h3;
    localparam S_END  = 3'h4;

    reg [2:0]  state_reg;
    reg [1:0]  kind_reg;
    reg        hint_reg;
    reg [7:0]  fid_reg;
    reg [15:0] total_reg;
    reg [15:0] written_reg;
    reg [7:0]  pfx_reg [0:15];
    reg [3:0]  pfx_len_reg;
    reg [3:0]  idx_reg;
    reg [7:0]  pay_len_reg;
    reg [7:0]  pay_cnt_reg;
    wire       f_valid;
    wire [7:0] f_data;
    wire       can_load;
    wire       pfx_left;
    wire       pay_left;
    wire       pop;
    wire [15:0] rem;
    wire [7:0] chunk;

    assign can_load = !tx_valid_o || tx_ready_i;
    assign pfx_left = idx_reg != pfx_len_reg;
    assign pay_left = pay_cnt_reg != pay_len_reg;
    assign pop      = (state_reg == S_SEND) && can_load && !pfx_left && pay_left && f_valid;
    assign rem      = total_reg - written_reg;
    assign chunk    = (rem > BLK) ? BLK[7:0] : rem[7:0];

    bfwa_fifo #(.W(8), .D(32), .AW(5)) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (data_valid_i),
        .in_ready_o  (data_ready_o),
        .in_data_i   (data_i),
        .out_valid_o (f_valid),
        .out_ready_i (pop),
        .out_data_o  (f_data)
    );

    // ************************************************************
    // command building and sequencing
    // ************************************************************
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg   <= S_IDLE;
            kind_reg    <= `BFWA_K_QRY;
            hint_reg    <= 1'b0;
            fid_reg     <= 8'h00;
            total_reg   <= 16'h0000;
            written_reg <= 16'h0000;
            pfx_len_reg <= 4'h0;
            idx_reg     <= 4'h0;
            pay_len_reg <= 8'h00;
            pay_cnt_reg <= 8'h00;
            tx_valid_o  <= 1'b0;
            tx_data_o   <= 8'h00;
            tx_last_o   <= 1'b0;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            err_o       <= 1'b0;
            err_sw_o    <= 16'h0000;
            activated_o <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (start_i && !activated_o) begin
                        fid_reg     <= file_id_i;
                        total_reg   <= total_len_i;
                        hint_reg    <= hint_en_i;
                        written_reg <= 16'h0000;
                        kind_reg    <= `BFWA_K_QRY;
                        busy_o      <= 1'b1;
                        done_o      <= 1'b0;
                        err_o       <= 1'b0;
                        state_reg   <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    idx_reg     <= 4'h0;
                    pay_cnt_reg <= 8'h00;
                    pay_len_reg <= 8'h00;
                    pfx_reg[2]  <= fid_reg;
                    pfx_reg[3]  <= 8'h00;
                    pfx_reg[5]  <= `BFWA_TAG_OFFSET;
                    pfx_reg[6]  <= 8'h01;
                    pfx_reg[7]  <= 8'h00;
                    pfx_reg[8]  <= `BFWA_TAG_PAYLOAD;
                    pfx_reg[9]  <= 8'h00;
                    pfx_reg[1]  <= `BFWA_INS_UPDATE;
                    case (kind_reg)
                        `BFWA_K_QRY: begin
                            pfx_reg[0]  <= `BFWA_CLA_PROP;
                            pfx_reg[1]  <= `BFWA_INS_QUERY;
                            pfx_reg[2]  <= `BFWA_QRY_P1;
                            pfx_reg[3]  <= `BFWA_QRY_P2;
                            pfx_reg[4]  <= `BFWA_QRY_LE;
                            pfx_len_reg <= 4'd5;
                        end
                        `BFWA_K_W1: begin
                            // offset zero, empty payload object
                            pfx_reg[0]  <= hint_reg ? `BFWA_CLA_PROP : `BFWA_CLA_SM;
                            pfx_reg[4]  <= hint_reg ? 8'h09 : 8'h05;
                            pfx_reg[10] <= `BFWA_TAG_SIZE;
                            pfx_reg[11] <= 8'h02;
                            pfx_reg[12] <= total_reg[15:8];
                            pfx_reg[13] <= total_reg[7:0];
                            pfx_len_reg <= hint_reg ? 4'd14 : 4'd10;
                        end
                        `BFWA_K_WN: begin
                            pfx_reg[0]  <= `BFWA_CLA_SM;
                            pay_len_reg <= chunk;
                            if (written_reg[15:8] == 8'h00) begin
                                pfx_reg[4]  <= chunk + 8'd5;
                                pfx_reg[7]  <= written_reg[7:0];
                                pfx_reg[9]  <= chunk;
                                pfx_len_reg <= 4'd10;
                            end else begin
                                pfx_reg[4]  <= chunk + 8'd6;
                                pfx_reg[6]  <= 8'h02;
                                pfx_reg[7]  <= written_reg[15:8];
                                pfx_reg[8]  <= written_reg[7:0];
                                pfx_reg[9]  <= `BFWA_TAG_PAYLOAD;
                                pfx_reg[10] <= chunk;
                                pfx_len_reg <= 4'd11;
                            end
                        end
                        default: begin
                            pfx_reg[0]  <= `BFWA_CLA_SM;
                            pfx_reg[1]  <= `BFWA_INS_ACTIVATE;
                            pfx_reg[2]  <= 8'h00;
                            pfx_len_reg <= 4'd4;
                        end
                    endcase
                    state_reg <= S_SEND;
                end
                S_SEND: begin
                    if (can_load) begin
                        if (pfx_left) begin
                            tx_valid_o <= 1'b1;
                            tx_data_o  <= pfx_reg[idx_reg];
                            tx_last_o  <= (idx_reg == pfx_len_reg - 4'd1) && !pay_left;
                            idx_reg    <= idx_reg + 4'd1;
                        end else if (pay_left) begin
                            tx_valid_o <= f_valid;
                            tx_data_o  <= f_data;
                            tx_last_o  <= (pay_cnt_reg == pay_len_reg - 8'd1);
                            if (f_valid) begin
                                pay_cnt_reg <= pay_cnt_reg + 8'd1;
                            end
                        end else begin
                            tx_valid_o <= 1'b0;
                            tx_last_o  <= 1'b0;
                            state_reg  <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    if (rsp_valid_i) begin
                        state_reg <= S_LOAD;
                        case (kind_reg)
                            `BFWA_K_QRY: begin
                                if (rsp_sw_i != `BFWA_SW_OK) begin
                                    err_sw_o  <= rsp_sw_i;
                                    state_reg <= S_END;
                                end else if (rsp_free_i < total_reg) begin
                                    err_sw_o  <= `BFWA_SW_LOCAL_NOROOM;
                                    state_reg <= S_END;
                                end else begin
                                    kind_reg <= `BFWA_K_W1;
                                end
                            end
                            `BFWA_K_W1: begin
                                if (rsp_sw_i == `BFWA_SW_OK) begin
                                    // no read-back between writes
                                    kind_reg <= (total_reg == 16'h0000) ?
                                                `BFWA_K_ACT : `BFWA_K_WN;
                                end else if (hint_reg) begin
                                    hint_reg <= 1'b0;
                                end else begin
                                    err_sw_o  <= rsp_sw_i;
                                    state_reg <= S_END;
                                end
                            end
                            `BFWA_K_WN: begin
                                if (rsp_sw_i == `BFWA_SW_OK) begin
                                    written_reg <= written_reg + {8'h00, pay_len_reg};
                                    if (rem == {8'h00, pay_len_reg}) begin
                                        kind_reg <= `BFWA_K_ACT;
                                    end
                                end else begin
                                    err_sw_o  <= rsp_sw_i;
                                    state_reg <= S_END;
                                end
                            end
                            default: begin
                                if (rsp_sw_i == `BFWA_SW_OK) begin
                                    activated_o <= 1'b1;
                                    err_sw_o    <= 16'h0000;
                                    done_o      <= 1'b1;
                                    busy_o      <= 1'b0;
                                    state_reg   <= S_IDLE;
                                end else begin
                                    err_sw_o  <= rsp_sw_i;
                                    state_reg <= S_END;
                                end
                            end
                        endcase
                    end
                end
                S_END: begin
                    err_o     <= 1'b1;
                    busy_o    <= 1'b0;
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule // bfwa_ctrl

//--- bfwa_defs.vh
// constants for the biometric file write-and-activate terminal controller
// assumes the link layer carries raw command bytes and returns parsed status words
`ifndef BFWA_DEFS_VH
`define BFWA_DEFS_VH

// class bytes
`define BFWA_CLA_SM       8'h0C
`define BFWA_CLA_PROP     8'h8C
// instruction bytes
`define BFWA_INS_UPDATE   8'hD7
`define BFWA_INS_ACTIVATE 8'h44
`define BFWA_INS_QUERY    8'h5F
// data object tags
`define BFWA_TAG_OFFSET   8'h54
`define BFWA_TAG_PAYLOAD  8'h53
`define BFWA_TAG_SIZE     8'hC0
// query parameters: current file, total byte count, short expected length
`define BFWA_QRY_P1       8'h00
`define BFWA_QRY_P2       8'h01
`define BFWA_QRY_LE       8'h00
// status words
`define BFWA_SW_OK        16'h9000
`define BFWA_SW_NOMEM     16'h6A84
`define BFWA_SW_BADDATA   16'h6A80
`define BFWA_SW_SECURITY  16'h6982
// status shown when free room is too small
`define BFWA_SW_LOCAL_NOROOM 16'h6A84
// command kinds
`define BFWA_K_QRY        2'h0
`define BFWA_K_W1         2'h1
`define BFWA_K_WN         2'h2
`define BFWA_K_ACT        2'h3

`endif

//--- bfwa_ctrl_props.sv
// port checker for the biometric file write-and-activate controller
// assumes one clock and an asynchronous active-high reset; bound onto bfwa_ctrl
`timescale 1ns/1ps
// ****************************************************************
// checker
// ****************************************************************
module bfwa_ctrl_props #(
    parameter BLK = 64
) (
    // clock and reset
    input wire        sys_clk_i,
    input wire        rst_i,
    // user side
    input wire        start_i,
    input wire        busy_o,
    input wire        done_o,
    input wire        err_o,
    input wire [15:0] err_sw_o,
    input wire        activated_o,
    // link side
    input wire        tx_valid_o,
    input wire        tx_ready_i,
    input wire [7:0]  tx_data_o,
    input wire        tx_last_o,
    input wire        rsp_valid_i,
    input wire [15:0] rsp_sw_i
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        start_i && !busy_o && !activated_o;
    endsequence
    sequence s_query;
        ##1 busy_o ##2 (tx_valid_o && tx_data_o == 8'h8C);
    endsequence
    AST_START_QUERY: assert property (s_take |-> s_query)
        else $error("query not sent three cycles after start");
    AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
        tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
        else $error("command byte changed before it was taken");
    AST_NO_TX_ACT: assert property (activated_o |-> !tx_valid_o)
        else $error("command byte sent after activation");
    AST_ACT_STICKY: assert property (activated_o |=> activated_o)
        else $error("activated flag dropped");
    AST_ACT_ON_OK: assert property ($rose(activated_o) |->
        $past(rsp_valid_i) && $past(rsp_sw_i) == 16'h9000)
        else $error("activated without success status");
    AST_DONE_ACT: assert property ($rose(done_o) |-> activated_o && !busy_o)
        else $error("done without activation");
    AST_ERR_BUSY: assert property ($rose(err_o) |-> !busy_o ##1 !busy_o)
        else $error("busy kept after error");
    AST_ERR_SW: assert property ($rose(err_o) |-> err_sw_o != 16'h9000)
        else $error("error reported with success status");
endmodule // bfwa_ctrl_props

bind bfwa_ctrl bfwa_ctrl_props #(.BLK(BLK)) u_props (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start_i), .busy_o(busy_o),
    .done_o(done_o), .err_o(err_o), .err_sw_o(err_sw_o), .activated_o(activated_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
    .tx_last_o(tx_last_o), .rsp_valid_i(rsp_valid_i), .rsp_sw_i(rsp_sw_i));

//--- bfwa_card_model.sv
// behavioural card holding the biometric data file
// assumes one command byte per accepted transfer, the last byte flagged
`timescale 1ns/1ps
// ****************************************************************
// card model
// ****************************************************************
module bfwa_card_model (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        rst_i,
    // command bytes
    input  wire        tx_valid_i,
    output reg         tx_ready_o,
    input  wire [7:0]  tx_data_i,
    input  wire        tx_last_i,
    // answers
    output reg         rsp_valid_o,
    output reg  [15:0] rsp_sw_o,
    output reg  [15:0] rsp_free_o,
    // behaviour controls
    input  wire [15:0] free_i,
    input  wire        rej_hint_i,
    input  wire [15:0] act_sw_i,
    input  wire        slow_i,
    input  wire        new_card_i
);
    reg [7:0]  cmd [0:255];
    reg        act_reg;
    reg [15:0] sw;
    integer    n, wpos, off, len, dly, pend;
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (new_card_i) begin
            act_reg = 1'b0;
            wpos = 0;
        end
        if (rst_i) begin
            n = 0;
            pend = 0;
            tx_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_sw_o <= 16'h0000;
            rsp_free_o <= 16'h0000;
        end else begin
            rsp_valid_o <= 1'b0;
            rsp_sw_o <= ~rsp_sw_o;
            rsp_free_o <= ~rsp_free_o;
            tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
            if (tx_valid_i && tx_ready_o) begin
                cmd[n] = tx_data_i;
                n = n + 1;
                if (tx_last_i) begin
                    sw = 16'h9000;
                    if (cmd[1] == 8'h44) begin
                        sw = act_sw_i;
                        if (sw == 16'h9000) act_reg = 1'b1;
                    end else if (cmd[1] == 8'hD7) begin
                        len = cmd[6];
                        off = (len == 1) ? cmd[7] : cmd[7] * 256 + cmd[8];
                        if (act_reg) sw = 16'h6982;
                        else if (cmd[4] != n - 5) sw = 16'h6A80;
                        else if (cmd[0] == 8'h8C && rej_hint_i) sw = 16'h6A80;
                        else if (off != wpos) sw = 16'h6A80;
                        else if (off + cmd[8 + len] > free_i) sw = 16'h6A84;
                        else wpos = off + cmd[8 + len];
                    end
                    n = 0;
                    pend = 1;
                    dly = slow_i ? 7 : 0;
                end
            end else if (pend == 1) begin
                if (dly == 0) begin
                    pend = 0;
                    rsp_valid_o <= 1'b1;
                    rsp_sw_o <= sw;
                    rsp_free_o <= free_i;
                end else dly = dly - 1;
            end
        end
    end
endmodule // bfwa_card_model

//--- tb_top.sv
// testbench for the biometric file controller against the card model
// assumes bfwa_ctrl with BLK of 127 and a 125 MHz clock
`timescale 1ns/1ps
// ****************************************************************
// testbench
// ****************************************************************
module tb_top;
    reg         sys_clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, hint_en_i = 1'b0;
    reg         data_valid_i = 1'b0, rej = 1'b0, slow = 1'b0, new_card = 1'b1, take = 1'b0;
    reg  [7:0]  file_id_i = 8'h00, data_i = 8'h00, nxt = 8'h00;
    reg  [15:0] total_len_i = 16'h0000, free_v = 16'hFFFF, act_sw = 16'h9000;
    wire        data_ready_o, tx_valid_o, tx_ready_i, tx_last_o, rsp_valid_i;
    wire        busy_o, done_o, err_o, activated_o;
    wire [7:0]  tx_data_o;
    wire [15:0] rsp_sw_i, rsp_free_i, err_sw_o;
    integer     errors = 0, total_checks = 0, fed = 0, to_feed = 0;
    reg  [7:0]  got[$], exp[$];
    always #4 sys_clk_i = ~sys_clk_i;
    bfwa_ctrl #(.BLK(127)) u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start_i),
        .file_id_i(file_id_i), .total_len_i(total_len_i), .hint_en_i(hint_en_i),
        .data_valid_i(data_valid_i), .data_ready_o(data_ready_o), .data_i(data_i),
        .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
        .tx_last_o(tx_last_o), .rsp_valid_i(rsp_valid_i), .rsp_sw_i(rsp_sw_i),
        .rsp_free_i(rsp_free_i), .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
        .err_sw_o(err_sw_o), .activated_o(activated_o));
    bfwa_card_model u_card (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o),
        .tx_ready_o(tx_ready_i), .tx_data_i(tx_data_o), .tx_last_i(tx_last_o),
        .rsp_valid_o(rsp_valid_i), .rsp_sw_o(rsp_sw_i), .rsp_free_o(rsp_free_i),
        .free_i(free_v), .rej_hint_i(rej), .act_sw_i(act_sw), .slow_i(slow),
        .new_card_i(new_card));
    always @(posedge sys_clk_i) begin
        take <= data_valid_i & data_ready_o;
        if (!rst_i && tx_valid_o && tx_ready_i) got.push_back(tx_data_o);
    end
    always @(negedge sys_clk_i) begin
        if (rst_i) begin
            fed = 0;
            nxt = 8'h00;
        end else if (take) begin
            fed = fed + 1;
            nxt = nxt + 8'h01;
        end
        data_valid_i = (fed < to_feed);
        data_i = data_valid_i ? nxt : ~nxt;
    end
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input [15:0] g, input [15:0] e);
        total_checks = total_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_stream;
        integer j;
        chk(16'(got.size()), 16'(exp.size()));
        for (j = 0; j < exp.size() && j < got.size(); j = j + 1) chk({8'h00, got[j]}, {8'h00, exp[j]});
    endtask
    task e(input [7:0] b);
        exp.push_back(b);
    endtask
    task e_query;
        e(8'h8C); e(8'h5F); e(8'h00); e(8'h01); e(8'h00);
    endtask
    task e_first(input [7:0] fid, input h, input [15:0] tot);
        e(h ? 8'h8C : 8'h0C); e(8'hD7); e(fid); e(8'h00); e(h ? 8'h09 : 8'h05);
        e(8'h54); e(8'h01); e(8'h00); e(8'h53); e(8'h00);
        if (h) begin
            e(8'hC0); e(8'h02); e(tot[15:8]); e(tot[7:0]);
        end
    endtask
    task e_rest(input [7:0] fid, input integer tot);
        integer off, n, j;
        for (off = 0; off < tot; off = off + n) begin
            n = (tot - off > 127) ? 127 : tot - off;
            e(8'h0C); e(8'hD7); e(fid); e(8'h00);
            if (off < 256) begin
                e(8'(n + 5)); e(8'h54); e(8'h01); e(8'(off));
            end else begin
                e(8'(n + 6)); e(8'h54); e(8'h02); e(8'(off >> 8)); e(8'(off));
            end
            e(8'h53); e(8'(n));
            for (j = 0; j < n; j = j + 1) e(8'(off + j));
        end
        e(8'h0C); e(8'h44); e(8'h00); e(8'h00);
    endtask
    task prep(input integer n);
        rst_i = 1'b1;
        new_card = 1'b1;
        to_feed = 0;
        got.delete();
        exp.delete();
        repeat (20) @(negedge sys_clk_i);
        new_card = 1'b0;
        rst_i = 1'b0;
        to_feed = n;
    endtask
    task go(input [7:0] fid, input h, input [15:0] tot);
        integer c;
        file_id_i = fid;
        hint_en_i = h;
        total_len_i = tot;
        start_i = 1'b1;
        @(negedge sys_clk_i);
        start_i = 1'b0;
        c = 0;
        while (!(done_o === 1'b1 || err_o === 1'b1) && c < 20000) begin
            @(negedge sys_clk_i);
            c = c + 1;
        end
        if (c >= 20000) begin
            errors = errors + 1;
            $display("[FAIL] %0t got %h exp %h", $time, busy_o, 1'b0);
            test_done;
        end
    endtask
    task t_plain;
        prep(400);
        slow = 1'b1;
        repeat (50) @(negedge sys_clk_i);
        chk(16'(fed), 16'h0020);
        chk({15'h0, data_ready_o}, 16'h0000);
        go(8'h1E, 1'b0, 16'h0190);
        e_query; e_first(8'h1E, 1'b0, 16'h0190); e_rest(8'h1E, 400);
        chk_stream;
        chk({14'h0, done_o, activated_o}, 16'h0003);
        start_i = 1'b1;
        @(negedge sys_clk_i);
        start_i = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        chk({15'h0, busy_o}, 16'h0000);
        chk(16'(got.size()), 16'(exp.size()));
        slow = 1'b0;
        $display("test plain done");
    endtask
    task t_hint(input r, input [15:0] tot);
        prep(tot);
        rej = r;
        slow = r;
        go(8'h02, 1'b1, tot);
        e_query; e_first(8'h02, 1'b1, tot);
        if (r) e_first(8'h02, 1'b0, tot);
        e_rest(8'h02, tot);
        chk_stream;
        chk({14'h0, done_o, err_o}, 16'h0002);
        rej = 1'b0;
        slow = 1'b0;
        $display("test hint done");
    endtask
    task t_noroom;
        prep(11);
        free_v = 16'h000A;
        go(8'h04, 1'b0, 16'h000B);
        e_query;
        chk_stream;
        chk(err_sw_o, 16'h6A84);
        chk({14'h0, err_o, activated_o}, 16'h0002);
        free_v = 16'hFFFF;
        $display("test noroom done");
    endtask
    task t_act_fail;
        prep(3);
        act_sw = 16'h6581;
        go(8'h05, 1'b0, 16'h0003);
        e_query; e_first(8'h05, 1'b0, 16'h0003); e_rest(8'h05, 3);
        chk_stream;
        chk(err_sw_o, 16'h6581);
        chk({14'h0, err_o, activated_o}, 16'h0002);
        act_sw = 16'h9000;
        $display("test activate fail done");
    endtask
    initial begin
        t_plain;
        t_hint(1'b1, 16'h0005);
        t_hint(1'b0, 16'h0000);
        t_noroom;
        t_act_fail;
        test_done;
    end
endmodule // tb_top
